// ===== src/amic_ctrl.sv
// converter mode register, result-ready handling and interrupt masking
`timescale 1ns/1ps

module amic_ctrl
	import amic_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire amic_pkg::amic_bus_t bus,
	output logic [31:0]            rdata,
	input  wire logic              convTick,
	input  wire logic              chopEnable,
	input  wire logic [2:0]        rawValid,
	input  wire logic [47:0]       rawData,
	input  wire logic [7:0]        extStatus,
	input  wire logic              coreDown,
	output amic_pkg::amic_ctrl_t   ctrl,
	output logic [2:0]             chanRun,
	output logic                   irq
);
	import amic_pkg::*;

	typedef enum logic [1:0] {
		AMIC_ST_STOP,
		AMIC_ST_RUN,
		AMIC_ST_HOLD
	} amic_state_t;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0]  irqMask;
	logic [7:0]  modeReg;
	logic [2:0]  chanEn;
	logic [2:0]  ready;
	logic        calDone;
	logic [15:0] result [CHANNELS];
	amic_state_t state;
	logic [1:0]  cycCount;
	logic        convDone;
	logic        calFinish;
	logic        singleFinish;
	logic [1:0]  next_cycCount;
	logic [1:0]  cycNeeded;
	logic [2:0]  opCode;
	logic [1:0]  pwrCode;
	logic        wrMode;
	logic        clrAll;
	logic        clrCur;
	logic        clrVolt;
	logic        clrTemp;
	logic [2:0]  loadEn;
	logic [15:0] status;

	assign opCode  = modeReg[MODE_OP_LSB +: 3];
	assign pwrCode = modeReg[MODE_PWR_LSB +: 2];
	assign wrMode  = bus.wr && (bus.addr == ADDR_MODE);

	// ---------------------------------------------------------------
	// read side effects on ready flags
	// ---------------------------------------------------------------
	// a read of the current result wipes every flag; with the current
	// converter off the other results take that role
	always_comb begin
		clrAll  = 1'b0;
		clrVolt = 1'b0;
		clrTemp = 1'b0;
		if (bus.rd && bus.addr == ADDR_CURRENT) begin
			clrAll = 1'b1;
		end else if (bus.rd && bus.addr == ADDR_VOLTAGE) begin
			clrAll  = !chanEn[0];
			clrVolt = 1'b1;
		end else if (bus.rd && bus.addr == ADDR_TEMP) begin
			clrAll  = !chanEn[0];
			clrTemp = 1'b1;
		end
		clrCur = clrAll;
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqMask <= RST_IRQ_MASK;
			chanEn  <= RST_CHAN_EN;
		end else if (bus.wr) begin
			if (bus.addr == ADDR_IRQ_MASK) begin
				irqMask <= bus.wdata[7:0];
			end else if (bus.addr == ADDR_CHAN_EN) begin
				chanEn <= bus.wdata[2:0];
			end
		end
	end

	// mode register; hardware drops back to idle after single or cal
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modeReg <= RST_MODE;
		end else if (wrMode) begin
			// bit 7 stored as written; software keeps it zero
			modeReg <= bus.wdata[7:0];
		end else if (calFinish || singleFinish) begin
			modeReg[MODE_OP_LSB +: 3] <= OP_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// conversion sequencer
	// ---------------------------------------------------------------
	// chopping needs an extra settling cycle per result
	assign cycNeeded = chopEnable ? CYC_CHOPPING_SELECT : CYC_NOCHOP;

	always_comb begin
		next_cycCount = cycCount;
		convDone      = 1'b0;
		if (state == AMIC_ST_RUN && convTick) begin
			if (cycCount + 2'h1 >= cycNeeded) begin
				convDone      = 1'b1;
				next_cycCount = 2'h0;
			end else begin
				next_cycCount = cycCount + 2'h1;
			end
		end
	end

	assign calFinish    = convDone && opCode == OP_OFFSET_CAL && !wrMode;
	assign singleFinish = convDone && opCode == OP_SINGLE && !wrMode;

	always_ff @(posedge clk_sys) begin
		if (rst || wrMode) begin
			state    <= AMIC_ST_STOP;
			cycCount <= 2'h0;
		end else begin
			cycCount <= next_cycCount;
			case (opCode)
				OP_CONTINUOUS: state <= AMIC_ST_RUN;
				OP_SINGLE, OP_OFFSET_CAL: begin
					state <= (state == AMIC_ST_HOLD) ? AMIC_ST_HOLD : AMIC_ST_RUN;
					if (convDone) begin
						state <= AMIC_ST_HOLD;
					end
				end
				OP_IDLE: state <= AMIC_ST_HOLD;
				default: state <= AMIC_ST_STOP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// result registers
	// ---------------------------------------------------------------
	// a pending result is kept until read, unless the core sleeps
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			loadEn[i] = rawValid[i] && chanEn[i] && state == AMIC_ST_RUN
				&& opCode != OP_OFFSET_CAL
				&& (!ready[i] || coreDown);
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (rst) begin
				result[i] <= 16'h0000;
			end else if (loadEn[i]) begin
				result[i] <= rawData[16*i +: 16];
			end
		end
	end

	// ready flags; a set in the cycle of a clearing read wins
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (rst || !chanEn[i]) begin
				ready[i] <= 1'b0;
			end else if (loadEn[i] || (calFinish && chanEn[i])) begin
				ready[i] <= 1'b1;
			end else if (clrAll || (i == 1 && clrVolt) || (i == 2 && clrTemp)) begin
				ready[i] <= 1'b0;
			end
		end
	end

	// calibration complete: set at end of offset cal, cleared on mode write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			calDone <= 1'b0;
		end else if (calFinish) begin
			calDone <= 1'b1;
		end else if (wrMode) begin
			calDone <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// status and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		status = {calDone, 7'h00, extStatus[7:3], ready};
	end

	// only low byte reaches the request line; upper bits are flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status[7:0] & irqMask);
		end
	end

	// ---------------------------------------------------------------
	// analog control outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl    <= '0;
			chanRun <= 3'h0;
		end else begin
			ctrl.resPath     <= modeReg[MODE_RES_BIT];
			// reference choice only matters in the low-power codes
			ctrl.refPrecise  <= (pwrCode == PWR_LOW || pwrCode == PWR_LOWPLUS)
				? modeReg[MODE_REF_BIT] : 1'b1;
			ctrl.analogOn    <= opCode != OP_POWERDOWN;
			ctrl.holdReset   <= state != AMIC_ST_RUN;
			ctrl.lowPowerOsc <= pwrCode == PWR_LOW;
			ctrl.offsetCal   <= opCode == OP_OFFSET_CAL && state == AMIC_ST_RUN;
			// code 11 treated as normal: undefined, nothing forced
			case (pwrCode)
				PWR_LOW: begin
					ctrl.gainForced <= 1'b1;
					ctrl.gainForce  <= GAIN_LOW;
				end
				PWR_LOWPLUS: begin
					ctrl.gainForced <= 1'b1;
					ctrl.gainForce  <= GAIN_LOWPLUS;
				end
				default: begin
					ctrl.gainForced <= 1'b0;
					ctrl.gainForce  <= 10'h000;
				end
			endcase
			chanRun <= (state == AMIC_ST_RUN) ? chanEn : 3'h0;
		end
	end

	// ---------------------------------------------------------------
	// register read port, data one cycle after strobe
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			if (bus.addr == ADDR_STATUS) begin
				rdata <= {16'h0000, status};
			end else if (bus.addr == ADDR_IRQ_MASK) begin
				rdata <= {24'h000000, irqMask};
			end else if (bus.addr == ADDR_MODE) begin
				rdata <= {24'h000000, modeReg};
			end else if (bus.addr == ADDR_CURRENT) begin
				rdata <= {16'h0000, result[0]};
			end else if (bus.addr == ADDR_VOLTAGE) begin
				rdata <= {16'h0000, result[1]};
			end else if (bus.addr == ADDR_TEMP) begin
				rdata <= {16'h0000, result[2]};
			end else if (bus.addr == ADDR_CHAN_EN) begin
				rdata <= {29'h00000000, chanEn};
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// unused reserved status inputs kept out of the low byte's ready bits
	logic unusedExt;
	assign unusedExt = ^extStatus[2:0];

endmodule : amic_ctrl

// ===== src/amic_pkg.sv
// package of register map, field layout and mode codes for converter mode and irq control
package amic_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [31:0] ADDR_STATUS    = 32'hFFFF0500;
	localparam logic [31:0] ADDR_IRQ_MASK  = 32'hFFFF0504;
	localparam logic [31:0] ADDR_MODE      = 32'hFFFF0508;
	localparam logic [31:0] ADDR_CURRENT   = 32'hFFFF0510;
	localparam logic [31:0] ADDR_VOLTAGE   = 32'hFFFF0514;
	localparam logic [31:0] ADDR_TEMP      = 32'hFFFF0518;
	localparam logic [31:0] ADDR_CHAN_EN   = 32'hFFFF051C;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_MODE     = 8'h00;
	localparam logic [2:0] RST_CHAN_EN  = 3'h0;

	// ---------------------------------------------------------------
	// mode register field positions
	// ---------------------------------------------------------------
	localparam int MODE_RSV_BIT  = 7;
	localparam int MODE_RES_BIT  = 5;
	localparam int MODE_REF_BIT  = 6; // reference select bit; bits 4:3 hold the power code
	localparam int MODE_PWR_LSB  = 3;
	localparam int MODE_OP_LSB   = 0;

	// ---------------------------------------------------------------
	// status register field positions
	// ---------------------------------------------------------------
	localparam int STA_RDY_LSB   = 0;
	localparam int STA_CAL_BIT   = 15;

	// ---------------------------------------------------------------
	// codes
	// ---------------------------------------------------------------
	localparam logic [1:0] PWR_NORMAL  = 2'h0;
	localparam logic [1:0] PWR_LOW     = 2'h1;
	localparam logic [1:0] PWR_LOWPLUS = 2'h2;

	localparam logic [2:0] OP_POWERDOWN  = 3'h0;
	localparam logic [2:0] OP_CONTINUOUS = 3'h1;
	localparam logic [2:0] OP_SINGLE     = 3'h2;
	localparam logic [2:0] OP_IDLE       = 3'h3;
	localparam logic [2:0] OP_OFFSET_CAL = 3'h4;

	localparam logic [9:0] GAIN_LOW     = 10'h080;
	localparam logic [9:0] GAIN_LOWPLUS = 10'h200;

	// converter cycles per settled result
	localparam logic [1:0] CYC_NOCHOP = 2'h2;
	localparam logic [1:0] CYC_CHOPPING_SELECT   = 2'h3;

	localparam int CHANNELS = 3;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} amic_bus_t;

	typedef struct packed {
		logic        refPrecise;
		logic        resPath;
		logic        analogOn;
		logic        holdReset;
		logic        lowPowerOsc;
		logic [9:0]  gainForce;
		logic        gainForced;
		logic        offsetCal;
	} amic_ctrl_t;

endpackage : amic_pkg

// ===== test/amic_ctrl_bench.sv
// self-checking bench for converter mode and irq control
`timescale 1ns/1ps
module amic_ctrl_bench;
	import amic_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	amic_bus_t   bus = '0;
	logic        convTick = 1'b0;
	logic        chopEnable = 1'b0;
	logic [2:0]  rawValid = 3'h0;
	logic [47:0] rawData = 48'h0;
	logic [7:0]  extStatus = 8'h00;
	logic        coreDown = 1'b0;
	logic [31:0] rdata;
	amic_ctrl_t  ctrl;
	logic [2:0]  chanRun;
	logic        irq;
	logic [31:0] v;
	int          mismatches = 0;
	int          checkCount = 0;

	always #5 clk_sys = ~clk_sys;
	amic_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .convTick(convTick),
		.chopEnable(chopEnable), .rawValid(rawValid), .rawData(rawData), .extStatus(extStatus),
		.coreDown(coreDown), .ctrl(ctrl), .chanRun(chanRun), .irq(irq));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// bus cycles; each ends 1 ns past the edge so strobes never toggle twice in a step
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic tick(input int n);
		repeat (n) begin
			convTick <= 1'b1;
			@(posedge clk_sys);
			convTick <= 1'b0;
			cyc(1);
		end
	endtask : tick
	task automatic load(input logic [2:0] m, input logic [47:0] d);
		rawData <= d;
		rawValid <= m;
		@(posedge clk_sys);
		rawValid <= 3'h0;
		#1;
	endtask : load

	task automatic t_reset();
		rd(ADDR_IRQ_MASK);
		chk(v, 32'h0);
		rd(ADDR_MODE);
		chk(v, 32'h0);
		rd(32'hFFFF0520);
		chk(v, 32'h0);
		chk(irq, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_irq();
		wr(ADDR_IRQ_MASK, 32'hFFFFFFFF);
		rd(ADDR_IRQ_MASK);
		chk(v, 32'hFF);
		wr(ADDR_IRQ_MASK, 32'h08);
		extStatus <= 8'h08;
		cyc(3);
		chk(irq, 1'b1);
		rd(ADDR_STATUS);
		chk(v, 32'h08);
		wr(ADDR_IRQ_MASK, 32'hF7);
		cyc(3);
		chk(irq, 1'b0);
		extStatus <= 8'h00;
		wr(ADDR_IRQ_MASK, 32'h0);
		$display("irq test done");
	endtask : t_irq
	task automatic t_results();
		wr(ADDR_CHAN_EN, 32'h7);
		wr(ADDR_MODE, 32'h01);
		cyc(2);
		chk(chanRun, 3'h7);
		chk(ctrl.holdReset, 1'b0);
		load(3'h7, 48'h3333_2222_1111);
		rd(ADDR_STATUS);
		chk(v, 32'h7);
		load(3'h7, 48'hCCCC_BBBB_AAAA);
		rd(ADDR_VOLTAGE);
		chk(v, 32'h2222);
		rd(ADDR_CURRENT);
		chk(v, 32'h1111);
		rd(ADDR_STATUS);
		chk(v, 32'h0);
		wr(ADDR_CHAN_EN, 32'h6);
		load(3'h6, 48'h5555_4444_0000);
		rd(ADDR_VOLTAGE);
		chk(v, 32'h4444);
		rd(ADDR_STATUS);
		chk(v, 32'h0);
		coreDown <= 1'b1;
		load(3'h6, 48'h7777_6666_0000);
		load(3'h6, 48'h9999_8888_0000);
		rd(ADDR_VOLTAGE);
		chk(v, 32'h8888);
		coreDown <= 1'b0;
		$display("result test done");
	endtask : t_results
	task automatic t_modes();
		for (int p = 0; p < 3; p++) begin
			wr(ADDR_MODE, 32'(p << 3) | 32'h3);
			cyc(2);
			chk({ctrl.gainForced, ctrl.lowPowerOsc}, {p != 0, p == 1});
			if (p != 0)
				chk(ctrl.gainForce, p == 1 ? GAIN_LOW : GAIN_LOWPLUS);
			chk(ctrl.refPrecise, p == 0);
			chk({ctrl.analogOn, ctrl.holdReset}, 2'h3);
		end
		wr(ADDR_MODE, 32'h4B);
		cyc(2);
		chk(ctrl.refPrecise, 1'b1);
		wr(ADDR_MODE, 32'h23);
		rd(ADDR_MODE);
		chk(v, 32'h23);
		chk(ctrl.resPath, 1'b1);
		wr(ADDR_MODE, 32'h0);
		cyc(2);
		chk({ctrl.analogOn, chanRun}, 4'h0);
		$display("mode test done");
	endtask : t_modes
	task automatic t_single();
		wr(ADDR_CHAN_EN, 32'h7);
		for (int c = 0; c < 2; c++) begin
			chopEnable <= c[0];
			wr(ADDR_MODE, {29'h0, OP_SINGLE});
			// sequencer only starts running the cycle after the mode write
			cyc(1);
			tick(1 + c);
			rd(ADDR_MODE);
			chk(v, 32'h2);
			tick(1);
			rd(ADDR_MODE);
			chk(v, 32'h3);
		end
		$display("single test done");
	endtask : t_single
	task automatic t_cal();
		rd(ADDR_CURRENT);
		chopEnable <= 1'b0;
		wr(ADDR_MODE, {29'h0, OP_OFFSET_CAL});
		cyc(2);
		chk(ctrl.offsetCal, 1'b1);
		tick(2);
		rd(ADDR_STATUS);
		chk(v, 32'h8007);
		rd(ADDR_MODE);
		chk(v, 32'h3);
		wr(ADDR_MODE, 32'h3);
		rd(ADDR_STATUS);
		chk(v, 32'h7);
		$display("calibration test done");
	endtask : t_cal

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// watchdog against a hung sequence
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_irq();
		t_results();
		t_modes();
		t_single();
		t_cal();
		complete_run();
	end
endmodule : amic_ctrl_bench

// ===== test/amic_ctrl_chk.sv
// bound port checker for converter mode and irq control
`timescale 1ns/1ps
module amic_ctrl_chk
	import amic_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 rst,
	input wire amic_pkg::amic_bus_t  bus,
	input wire logic [31:0]          rdata,
	input wire logic [2:0]           rawValid,
	input wire amic_pkg::amic_ctrl_t ctrl,
	input wire logic                 irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0] maskSh;
	// shadow of mask writes, so irq can be judged from the ports alone
	always_ff @(posedge clk_sys) begin
		if (rst)
			maskSh <= 8'h00;
		else if (bus.wr && bus.addr == ADDR_IRQ_MASK)
			maskSh <= bus.wdata[7:0];
	end
	a_mask_read: assert property ((bus.wr && bus.addr == ADDR_IRQ_MASK) ##1
		(bus.rd && bus.addr == ADDR_IRQ_MASK) |=> rdata == {24'h0, $past(bus.wdata[7:0], 2)})
		else $error("mask readback differs");
	a_irq_off: assert property (maskSh == 8'h00 ##1 maskSh == 8'h00 |-> !irq)
		else $error("irq with all sources masked");
	a_gain_low: assert property (ctrl.lowPowerOsc |-> ctrl.gainForced && ctrl.gainForce == GAIN_LOW)
		else $error("low power gain wrong");
	a_gain_plus: assert property (ctrl.gainForced && !ctrl.lowPowerOsc |->
		ctrl.gainForce == GAIN_LOWPLUS) else $error("low power plus gain wrong");
	// normal mode keeps the precision reference; the select bit counts only in low power
	a_ref_lowpwr: assert property ((bus.wr && bus.addr == ADDR_MODE) |-> ##2
		ctrl.refPrecise == (($past(bus.wdata[MODE_PWR_LSB +: 2], 2) == PWR_LOW
		|| $past(bus.wdata[MODE_PWR_LSB +: 2], 2) == PWR_LOWPLUS)
		? $past(bus.wdata[MODE_REF_BIT], 2) : 1'b1)) else $error("reference select wrong");
	a_pdown_all: assert property ((bus.wr && bus.addr == ADDR_MODE &&
		bus.wdata[2:0] == OP_POWERDOWN) ##1 !bus.wr |=> !ctrl.analogOn) else $error("not powered down");
	a_idle_hold: assert property ((bus.wr && bus.addr == ADDR_MODE &&
		bus.wdata[2:0] == OP_IDLE) ##1 !bus.wr |=> ctrl.analogOn && ctrl.holdReset)
		else $error("idle not held in reset");
	a_cur_clear: assert property ((bus.rd && bus.addr == ADDR_CURRENT && rawValid == 3'h0) ##1
		(bus.rd && bus.addr == ADDR_STATUS && rawValid == 3'h0 && !ctrl.offsetCal) |=>
		rdata[2:0] == 3'h0) else $error("ready flags survive current read");
endmodule : amic_ctrl_chk

bind amic_ctrl amic_ctrl_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
	.rawValid(rawValid), .ctrl(ctrl), .irq(irq));
